// *** rtl/pmew_consts.vh ***
// constants of the wake event controller: offsets, fields, resets, timing
// assumes a 10 MHz device clock
`ifndef PMEW_CONSTS_VH
`define PMEW_CONSTS_VH
// -----------------------------------------------------------------
// register offsets
// -----------------------------------------------------------------
`define PMEW_OFS_PWR_CTL    12'h014
`define PMEW_OFS_PIN_WAKE   12'h020
`define PMEW_OFS_FLAG_ATTRIBUTES  12'h068
`define PMEW_OFS_STALL_BASE 12'h0B0
// -----------------------------------------------------------------
// power_mgmt_control fields
// -----------------------------------------------------------------
`define PMEW_PC_SRC_LSB     0
`define PMEW_PC_SRC_W       6
`define PMEW_PC_PHYSAVE_BIT 8
`define PMEW_PC_WAKEMODE    16
`define PMEW_PC_READY       17
`define PMEW_PC_LOADING     18
// -----------------------------------------------------------------
// flag_attributes fields
// -----------------------------------------------------------------
`define PMEW_FA_WAKE_EN     0
`define PMEW_FA_PULSE       1
`define PMEW_FA_POL_HIGH    2
`define PMEW_FA_PUSHPULL    3
`define PMEW_FA_LAN_SEL     4
`define PMEW_FA_SELF_PWR    5
`define PMEW_FA_NVM_OK      6
`define PMEW_FA_SRC_EN_LSB  8
// -----------------------------------------------------------------
// reset values
// -----------------------------------------------------------------
`define PMEW_RST_PWR_CTL    32'h0000_0000
`define PMEW_RST_PIN_WAKE   32'h0000_0000
`define PMEW_RST_FLAG_ATTRIBUTES  32'h0000_0000
// -----------------------------------------------------------------
// timing: 10 MHz clock
// -----------------------------------------------------------------
`define PMEW_CLK_KHZ        10000
`define PMEW_VALID_OTP_MS   1
`define PMEW_VALID_E2P_MS   16
// cycle counts at 10 MHz: 1 ms and 16 ms, sized to the 24-bit counter
`define PMEW_CYC_OTP        24'h002710
`define PMEW_CYC_E2P        24'h027100
`define PMEW_PULSE_CYC      16'h0064
`endif

// *** rtl/pmew_sync2.v ***
// two-flop synchroniser for one asynchronous level
// assumes one clock domain, async active-low reset
`timescale 1ns/1ns
module pmew_sync2 (
   input  wire ref_clk_i,
   input  wire reset_n_i,
   input  wire clk_en_i,
   input  wire din_i,
   output reg  dout_o
);
   reg meta_q;
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         meta_q <= 1'b0;
         dout_o <= 1'b0;
      end else if (clk_en_i) begin
         meta_q <= din_i;
         dout_o <= meta_q;
      end
   end
endmodule

// *** rtl/pmew_wake_controller.v ***
// power management wake event controller: sources, wake output, registers
// assumes register port strobes on ref_clk_i; pins and sources asynchronous
//
// Overview of operation
// - wake signalling only self powered with nvm
// - drive wake output on enabled event
// - sample mode select when clear released
// - mode 1 stays waiting, 0 resumes normal
// - output valid 1 ms otp, 16 ms eeprom
// - no nvm: only software-configured sources wake
// - general pins wake with enable and polarity
// - magic packet raises wake event
// - frame filter match raises wake event
// - perfect destination match raises wake event
// - broadcast frame raises wake event
// - link partner detection raises wake event
// - wake enable flag gates waiting mode
// - decode level, polarity and buffer type
// - clear or power-on reset reloads nvm
// - power-on with mode 1 enters waiting
// - optional phy saving during waiting mode
// - stall accesses at 0B0h and above when unconfigured
`timescale 1ns/1ns
`include "pmew_consts.vh"
module pmew_wake_controller #(
   parameter [23:0] VALID_OTP_CYC = `PMEW_CYC_OTP,
   parameter [23:0] VALID_E2P_CYC = `PMEW_CYC_E2P
) (
   input  wire        ref_clk_i,
   input  wire        reset_n_i,
   input  wire        clk_en_i,
   input  wire        wake_clear_in_n_i,
   input  wire        wake_mode_select_i,
   input  wire        bus_power_detect_i,
   input  wire [7:0]  gpio_i,
   input  wire        magic_pkt_i,
   input  wire        wakeup_frame_filter_i,
   input  wire        perfect_da_i,
   input  wire        broadcast_i,
   input  wire        link_partner_i,
   input  wire        nvm_present_i,
   input  wire        nvm_eeprom_i,
   input  wire        usb_configured_i,
   input  wire        reg_wr_i,
   input  wire        reg_rd_i,
   input  wire [11:0] reg_addr_i,
   input  wire [31:0] reg_wdata_i,
   output reg  [31:0] reg_rdata_o,
   output reg         reg_ack_o,
   output reg         reg_stall_o,
   output reg         wake_event_out_n_o,
   output reg         wake_event_oe_n_o,
   output reg         wake_mode_active_o,
   output reg         nvm_reload_o,
   output reg         phy_saving_enable_o
);
   // -----------------------------------------------------------------
   // state codes
   // -----------------------------------------------------------------
   localparam [3:0] ST_CLEAR  = 4'h1;
   localparam [3:0] ST_CONFIG = 4'h2;
   localparam [3:0] ST_NORMAL = 4'h4;
   localparam [3:0] ST_WAIT   = 4'h8;

   reg  [3:0]  state_q;
   reg  [3:0]  state_d;
   reg  [31:0] pwr_ctl_q;
   reg  [31:0] pin_wake_q;
   reg  [31:0] flag_attributes_q;
   reg  [23:0] cfg_cnt_q;
   reg  [15:0] pulse_cnt_q;
   reg         mode_smp_q;
   reg         clear_seen_q;
   reg         latched_q;
   reg         por_done_q;
   wire        clr_n_s;
   wire        mode_s;
   wire        vbus_s;
   wire [7:0]  gpio_s;
   wire [5:0]  net_s;
   wire [13:0] sync_in;
   wire [13:0] sync_out;

   // -----------------------------------------------------------------
   // input synchronisers
   // -----------------------------------------------------------------
   assign sync_in = {wake_clear_in_n_i, wake_mode_select_i, bus_power_detect_i,
                     gpio_i[7:0], magic_pkt_i, wakeup_frame_filter_i, perfect_da_i};
   genvar gi;
   generate
      for (gi = 0; gi < 14; gi = gi + 1) begin : g_sync
         pmew_sync2 u_sync (
            .ref_clk_i (ref_clk_i),
            .reset_n_i (reset_n_i),
            .clk_en_i  (clk_en_i),
            .din_i     (sync_in[gi]),
            .dout_o    (sync_out[gi])
         );
      end
   endgenerate
   pmew_sync2 u_sync_bc (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .din_i     (broadcast_i),
      .dout_o    (net_s[1])
   );
   pmew_sync2 u_sync_lk (
      .ref_clk_i (ref_clk_i),
      .reset_n_i (reset_n_i),
      .clk_en_i  (clk_en_i),
      .din_i     (link_partner_i),
      .dout_o    (net_s[0])
   );
   assign clr_n_s   = sync_out[13];
   assign mode_s    = sync_out[12];
   assign vbus_s    = sync_out[11];
   assign gpio_s    = sync_out[10:3];
   assign net_s[5]  = sync_out[2];
   assign net_s[4]  = sync_out[1];
   assign net_s[3]  = sync_out[0];
   assign net_s[2]  = 1'b0;

   // -----------------------------------------------------------------
   // wake sources
   // -----------------------------------------------------------------
   wire       fa_wake_en  = flag_attributes_q[`PMEW_FA_WAKE_EN];
   wire       fa_pulse    = flag_attributes_q[`PMEW_FA_PULSE];
   wire       fa_pol_high = flag_attributes_q[`PMEW_FA_POL_HIGH];
   wire       fa_pushpull = flag_attributes_q[`PMEW_FA_PUSHPULL];
   wire       fa_lan_sel  = flag_attributes_q[`PMEW_FA_LAN_SEL];
   wire [5:0] src_en      = flag_attributes_q[`PMEW_FA_SRC_EN_LSB +: 6];
   wire       capable = flag_attributes_q[`PMEW_FA_SELF_PWR] &
                        (flag_attributes_q[`PMEW_FA_NVM_OK] | nvm_present_i);
   wire [7:0] gpio_hit = pin_wake_q[7:0] & ~(gpio_s ^ pin_wake_q[15:8]);
   wire [5:0] net_hit = {net_s[5:3], net_s[1], net_s[0], 1'b0} & src_en &
                        {6{fa_lan_sel}};
   wire       any_hit = (|gpio_hit) | (|net_hit);
   wire       wait_ok = fa_wake_en & capable;

   // -----------------------------------------------------------------
   // sequencing state machine
   // -----------------------------------------------------------------
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_CLEAR: begin
            if (clr_n_s)
               state_d = ST_CONFIG;
         end
         ST_CONFIG: begin
            if (cfg_cnt_q == 24'h000000)
               state_d = (mode_smp_q & wait_ok) ? ST_WAIT : ST_NORMAL;
         end
         ST_NORMAL: begin
            if (!clr_n_s)
               state_d = ST_CLEAR;
         end
         ST_WAIT: begin
            if (!clr_n_s)
               state_d = ST_CLEAR;
         end
         default: state_d = ST_CLEAR;
      endcase
   end

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         state_q      <= ST_CLEAR;
         cfg_cnt_q    <= 24'h000000;
         mode_smp_q   <= 1'b0;
         clear_seen_q <= 1'b0;
         por_done_q   <= 1'b0;
         nvm_reload_o <= 1'b0;
      end else if (clk_en_i) begin
         state_q      <= state_d;
         clear_seen_q <= ~clr_n_s;
         nvm_reload_o <= 1'b0;
         if (state_q == ST_CLEAR && clr_n_s) begin
            mode_smp_q   <= mode_s;
            por_done_q   <= 1'b1;
            nvm_reload_o <= 1'b1;
            cfg_cnt_q    <= (nvm_eeprom_i ? VALID_E2P_CYC : VALID_OTP_CYC) - 24'h000001;
         end else if (state_q == ST_CONFIG && cfg_cnt_q != 24'h000000) begin
            cfg_cnt_q <= cfg_cnt_q - 24'h000001;
         end
      end
   end

   // -----------------------------------------------------------------
   // wake output
   // -----------------------------------------------------------------
   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         latched_q           <= 1'b0;
         pulse_cnt_q         <= 16'h0000;
         wake_event_out_n_o  <= 1'b1;
         wake_event_oe_n_o   <= 1'b1;
         wake_mode_active_o  <= 1'b0;
         phy_saving_enable_o <= 1'b0;
      end else if (clk_en_i) begin
         wake_mode_active_o  <= (state_q == ST_WAIT);
         phy_saving_enable_o <= (state_q == ST_WAIT) & pwr_ctl_q[`PMEW_PC_PHYSAVE_BIT];
         if (!clr_n_s) begin
            latched_q   <= 1'b0;
            pulse_cnt_q <= 16'h0000;
         end else if (state_q == ST_WAIT && any_hit && !latched_q) begin
            latched_q   <= 1'b1;
            pulse_cnt_q <= `PMEW_PULSE_CYC;
         end else if (pulse_cnt_q != 16'h0000) begin
            pulse_cnt_q <= pulse_cnt_q - 16'h0001;
         end
         if (state_q == ST_CONFIG || state_q == ST_CLEAR) begin
            wake_event_oe_n_o  <= 1'b1;
            wake_event_out_n_o <= 1'b1;
         end else begin
            wake_event_out_n_o <= ((fa_pulse ? (pulse_cnt_q != 16'h0000) : latched_q)
                                   ^ ~fa_pol_high);
            wake_event_oe_n_o  <= ~(fa_pushpull |
                                   ((fa_pulse ? (pulse_cnt_q != 16'h0000) : latched_q)
                                    ^ fa_pol_high));
         end
      end
   end

   // -----------------------------------------------------------------
   // register port
   // -----------------------------------------------------------------
   // upper space stalls unconfigured
   wire stall = (reg_addr_i >= `PMEW_OFS_STALL_BASE) & ~usb_configured_i;
   wire [31:0] pc_status = {12'h000, ~por_done_q, (state_q == ST_CONFIG),
                            (state_q != ST_CONFIG && state_q != ST_CLEAR),
                            (state_q == ST_WAIT), 7'h00, pwr_ctl_q[8], 2'b00,
                            vbus_s, latched_q, 4'h0};
   wire [31:0] pc_view = pc_status | {26'h0000000, net_hit};

   always @(posedge ref_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pwr_ctl_q   <= `PMEW_RST_PWR_CTL;
         pin_wake_q  <= `PMEW_RST_PIN_WAKE;
         flag_attributes_q <= `PMEW_RST_FLAG_ATTRIBUTES;
         reg_rdata_o <= 32'h0000_0000;
         reg_ack_o   <= 1'b0;
         reg_stall_o <= 1'b0;
      end else if (clk_en_i) begin
         reg_ack_o   <= (reg_wr_i | reg_rd_i) & ~stall;
         reg_stall_o <= (reg_wr_i | reg_rd_i) & stall;
         reg_rdata_o <= 32'h0000_0000;
         if (reg_wr_i && !stall) begin
            case (reg_addr_i)
               `PMEW_OFS_PWR_CTL:   pwr_ctl_q   <= reg_wdata_i & 32'h0000_0100;
               `PMEW_OFS_PIN_WAKE:  pin_wake_q  <= reg_wdata_i & 32'h0000_FFFF;
               `PMEW_OFS_FLAG_ATTRIBUTES: flag_attributes_q <= reg_wdata_i & 32'h0000_3FFF;
               default: ;
            endcase
         end
         if (reg_rd_i && !stall) begin
            case (reg_addr_i)
               `PMEW_OFS_PWR_CTL:   reg_rdata_o <= pc_view;
               `PMEW_OFS_PIN_WAKE:  reg_rdata_o <= pin_wake_q;
               `PMEW_OFS_FLAG_ATTRIBUTES: reg_rdata_o <= flag_attributes_q;
               default:             reg_rdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule

// *** tb/pmew_ec_model.sv ***
// model of the embedded controller on the wake pins
// assumes a pull-up on the wake line; bench calls clear_cycle
`timescale 1ns/1ns
module pmew_ec_model (
   input  wire ref_clk_i,
   input  wire wake_event_out_n_i,
   input  wire wake_event_oe_n_i,
   output reg  wake_clear_in_n_o,
   output reg  wake_mode_select_o,
   output reg  bus_power_detect_o,
   output wire wake_line_o
);
   // released line floats up to the pull-up level
   assign wake_line_o = wake_event_oe_n_i ? 1'b1 : wake_event_out_n_i;
   initial begin
      wake_clear_in_n_o = 1'b1;
      wake_mode_select_o = 1'b0;
      bus_power_detect_o = 1'b0;
   end
   // power detect, then mode, then clear
   task clear_cycle(input logic mode, input int cfg_cyc);
      @(posedge ref_clk_i);
      bus_power_detect_o <= 1'b1;
      @(posedge ref_clk_i);
      wake_mode_select_o <= mode;
      @(posedge ref_clk_i);
      wake_clear_in_n_o <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      wake_clear_in_n_o <= 1'b1;
      repeat (cfg_cyc + 6) @(posedge ref_clk_i);
   endtask
endmodule

// *** tb/pmew_wake_controller_chk.sv ***
// port checker of the wake event controller, bound to the top module
// assumes one clock, async active-low reset, clear pin held high in reset
`timescale 1ns/1ns
module pmew_chk (
   input wire        ref_clk_i,
   input wire        reset_n_i,
   input wire        clk_en_i,
   input wire        wake_clear_in_n_i,
   input wire        wake_mode_select_i,
   input wire        usb_configured_i,
   input wire        reg_wr_i,
   input wire        reg_rd_i,
   input wire [11:0] reg_addr_i,
   input wire        reg_ack_o,
   input wire        reg_stall_o,
   input wire        wake_event_oe_n_o,
   input wire        wake_mode_active_o,
   input wire        nvm_reload_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);
   // -----------------------------------------------------------------
   // sequences
   // -----------------------------------------------------------------
   sequence s_req; clk_en_i && (reg_wr_i || reg_rd_i); endsequence
   sequence s_hi; reg_addr_i >= 12'h0B0 && !usb_configured_i; endsequence
   sequence s_norm; nvm_reload_o && !wake_mode_select_i; endsequence
   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_stall_high_ofs: assert property (s_req ##0 s_hi |=> reg_stall_o && !reg_ack_o)
      else $error("high offset not stalled");
   a_ack_low_ofs: assert property (s_req ##0 !(reg_addr_i >= 12'h0B0 && !usb_configured_i)
      |=> reg_ack_o && !reg_stall_o)
      else $error("access not acknowledged");
   a_ack_has_cause: assert property (reg_ack_o |-> $past(clk_en_i && (reg_rd_i || reg_wr_i)))
      else $error("ack without request");
   a_reload_on_clear: assert property ($rose(wake_clear_in_n_i) |-> ##[1:5] nvm_reload_o)
      else $error("no reload after clear");
   a_clear_no_wait: assert property (!wake_clear_in_n_i [*6] |-> !wake_mode_active_o)
      else $error("waiting while clear held");
   a_clear_undriven: assert property (!wake_clear_in_n_i [*6] |-> wake_event_oe_n_o)
      else $error("wake output driven during clear");
   a_config_undriven: assert property (nvm_reload_o |=> wake_event_oe_n_o [*8])
      else $error("wake output driven while configuring");
   a_config_no_wait: assert property (nvm_reload_o |=> !wake_mode_active_o [*8])
      else $error("waiting entered while configuring");
   a_mode_zero_normal: assert property (s_norm |=> !wake_mode_active_o until !wake_clear_in_n_i)
      else $error("mode zero entered waiting");
endmodule
bind pmew_wake_controller pmew_chk i_pmew_chk (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
   .clk_en_i(clk_en_i), .wake_clear_in_n_i(wake_clear_in_n_i),
   .wake_mode_select_i(wake_mode_select_i), .usb_configured_i(usb_configured_i),
   .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_ack_o(reg_ack_o),
   .reg_stall_o(reg_stall_o), .wake_event_oe_n_o(wake_event_oe_n_o),
   .wake_mode_active_o(wake_mode_active_o), .nvm_reload_o(nvm_reload_o));

// *** tb/test_pmew_wake_controller.sv ***
// self-checking bench of the wake event controller
// assumes controller model on the wake pins and short config counts
`timescale 1ns/1ns
`include "pmew_consts.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_pmew_wake_controller;
   reg        ref_clk_i = 1'b0, reset_n_i = 1'b0, usb_cfg = 1'b0, eep = 1'b0;
   reg        reg_wr_i = 1'b0, reg_rd_i = 1'b0, ak, st;
   reg [11:0] reg_addr_i = 12'h000;
   reg [31:0] reg_wdata_i = 32'h0, q;
   reg [7:0]  gpio_i = 8'h02;
   reg [4:0]  src = 5'h00;
   wire [31:0] reg_rdata_o;
   wire       reg_ack_o, reg_stall_o, out_n, oe_n, wake_mode_active_o, clr_n, mode, vbus, line;
   wire       phy;
   int        i, compares = 0, num_errors = 0, cycles = 0;
   always #50 ref_clk_i = ~ref_clk_i;
   pmew_wake_controller #(.VALID_OTP_CYC(24'd20), .VALID_E2P_CYC(24'd40)) i_pmew_wake_controller (
      .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1), .wake_clear_in_n_i(clr_n),
      .wake_mode_select_i(mode), .bus_power_detect_i(vbus), .gpio_i(gpio_i),
      .magic_pkt_i(src[0]), .wakeup_frame_filter_i(src[1]), .perfect_da_i(src[2]),
      .broadcast_i(src[3]), .link_partner_i(src[4]), .nvm_present_i(1'b1), .nvm_eeprom_i(eep),
      .usb_configured_i(usb_cfg), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_ack_o(reg_ack_o), .reg_stall_o(reg_stall_o), .wake_event_out_n_o(out_n),
      .wake_event_oe_n_o(oe_n), .wake_mode_active_o(wake_mode_active_o), .nvm_reload_o(),
      .phy_saving_enable_o(phy));
   pmew_ec_model i_pmew_ec_model (.ref_clk_i(ref_clk_i), .wake_event_out_n_i(out_n),
      .wake_event_oe_n_i(oe_n), .wake_clear_in_n_o(clr_n), .wake_mode_select_o(mode),
      .bus_power_detect_o(vbus), .wake_line_o(line));
   // -----------------------------------------------------------------
   // tasks
   // -----------------------------------------------------------------
   task acc(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      reg_wr_i <= wr;
      reg_rd_i <= !wr;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
      reg_rd_i <= 1'b0;
      #1 q = reg_rdata_o;
      {ak, st} = {reg_ack_o, reg_stall_o};
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0);
      `CHK({ak, q}, {1'b1, e})
   endtask
   // sources 0 and 1 are gpio pins 0 and 1, sources 2 to 6 drive src
   task set_src(input int n, input logic v);
      if (n == 0) gpio_i <= v ? 8'h03 : 8'h02;
      else if (n == 1) gpio_i <= v ? 8'h00 : 8'h02;
      else src[n-2] <= v;
   endtask
   task complete_run;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         num_errors++;
         complete_run;
      end
   end
   // -----------------------------------------------------------------
   // tests
   // -----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge ref_clk_i);
      reset_n_i <= 1'b1;
      rd_chk(`PMEW_OFS_PIN_WAKE, `PMEW_RST_PIN_WAKE);
      rd_chk(`PMEW_OFS_FLAG_ATTRIBUTES, `PMEW_RST_FLAG_ATTRIBUTES);
      acc(1'b1, 12'h030, 32'hFFFF_FFFF);
      rd_chk(12'h030, 32'h0000_0000);
      rd_chk(12'h0AC, 32'h0000_0000);
      acc(1'b0, `PMEW_OFS_STALL_BASE, 32'h0);
      `CHK({ak, st}, 2'b01)
      usb_cfg <= 1'b1;
      rd_chk(`PMEW_OFS_STALL_BASE, 32'h0000_0000);
      $display("test registers done");
      acc(1'b1, `PMEW_OFS_PWR_CTL, 32'hFFFF_FFFF);
      acc(1'b1, `PMEW_OFS_PIN_WAKE, 32'h0000_0103);
      rd_chk(`PMEW_OFS_PIN_WAKE, 32'h0000_0103);
      // pins, then magic, filter, exact address, broadcast, link
      for (i = 0; i < 7; i++) begin
         acc(1'b1, `PMEW_OFS_FLAG_ATTRIBUTES, 32'h0000_3E7D);
         i_pmew_ec_model.clear_cycle(1'b1, 20);
         `CHK({wake_mode_active_o, line}, 2'b10)
         set_src(i, 1'b1);
         repeat (4) @(posedge ref_clk_i);
         set_src(i, 1'b0);
         repeat (20) @(posedge ref_clk_i);
         #1 `CHK({line, oe_n}, 2'b10)
      end
      $display("test wake sources done");
      // no self power, no wake enable, mode zero
      for (i = 0; i < 3; i++) begin
         acc(1'b1, `PMEW_OFS_FLAG_ATTRIBUTES, i == 0 ? 32'h0000_3E5D : i == 1 ? 32'h3E7C : 32'h3E7D);
         i_pmew_ec_model.clear_cycle(i != 2, 20);
         `CHK(wake_mode_active_o, 1'b0)
      end
      $display("test refusals done");
      eep <= 1'b1;
      acc(1'b1, `PMEW_OFS_FLAG_ATTRIBUTES, 32'h0000_3E73);
      i_pmew_ec_model.clear_cycle(1'b1, 40);
      `CHK({wake_mode_active_o, line, oe_n}, 3'b111)
      rd_chk(`PMEW_OFS_PWR_CTL, 32'h0003_0120);
      `CHK(phy, 1'b1)
      set_src(2, 1'b1);
      repeat (4) @(posedge ref_clk_i);
      set_src(2, 1'b0);
      repeat (40) @(posedge ref_clk_i);
      #1 `CHK({line, oe_n}, 2'b00)
      repeat (`PMEW_PULSE_CYC) @(posedge ref_clk_i);
      #1 `CHK({line, oe_n}, 2'b11)
      $display("test pulse open drain done");
      complete_run;
   end
endmodule
